// file: rtl/emc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH
`define EMC_SFR_PAGE      8'h00
`define EMC_CFG_ADDR      8'hab
`define EMC_TC_ADDR       8'haf
`define EMC_CFG_RESET     8'h03
`define EMC_TC_RESET      8'hff
`define EMC_CFG_MODE_HI   3
`define EMC_CFG_MODE_LO   2
`define EMC_CFG_ALE_HI    1
`define EMC_CFG_ALE_LO    0
`define EMC_TC_SETUP_HI   7
`define EMC_TC_SETUP_LO   6
`define EMC_TC_STROBE_HI  5
`define EMC_TC_STROBE_LO  2
`define EMC_TC_HOLD_HI    1
`define EMC_TC_HOLD_LO    0
`define EMC_FIXED_CYCLES  6'h04
`define EMC_TAIL_LOAD     4'h2
`endif

// file: rtl/emc_pkg.sv
// Types shared by the external memory interface
package emc_pkg;
  // Interface operating modes
  typedef enum logic [1:0] {
    EMC_MODE_INTERNAL  = 2'b00,
    EMC_MODE_SPLIT     = 2'b01,
    EMC_MODE_SPLIT_BS  = 2'b10,
    EMC_MODE_EXTERNAL  = 2'b11
  } emc_mode_t;
  // Access sequencer states
  typedef enum logic [2:0] {
    EMC_IDLE, EMC_START, EMC_ALE_HI, EMC_ALE_LO, EMC_SETUP, EMC_STROBE, EMC_HOLD, EMC_TAIL
  } emc_st_t;
  // Whole module state
  typedef struct packed {
    emc_st_t    st;
    logic [3:0] cnt;
    logic [1:0] mode;
    logic [1:0] alew;
    logic [7:0] tc;
    logic [1:0] setup_cyc;
    logic [3:0] strobe_cyc;
    logic [1:0] hold_cyc;
    logic [1:0] aw;
    logic       mux;
    logic       wr;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] sfr_rdata;
    logic       done;
    logic       offchip;
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       ad_oe_n;
    logic [7:0] ad_out;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
  } emc_state_t;
endpackage

// file: rtl/emc_ext_mem_if.sv
// External memory interface: configuration registers and access sequencer
// Operation
// - Mode field picks internal, split, or external
// - Latch strobe phases last field plus one
// - Upper configuration bits read zero, ignore writes
// - Configuration at 0xAB, resets mode 00, width 11
// - Timing register at 0xAF, fields, resets ones
// - External-only mode sends all moves off-chip
// - Access lasts timing plus four, plus latch
// - Setup field gives zero to three cycles
`timescale 1ns/1ps
`include "emc_defs.svh"
module emc_ext_mem_if
  import emc_pkg::*;
#(
  parameter logic [15:0] XRAM_SIZE = 16'h1000  // On-chip expansion RAM boundary
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  sfr_page,     // Special-register page
  input  wire logic [7:0]  sfr_addr,     // Special-register address
  input  wire logic        sfr_wr,       // Register write strobe
  input  wire logic [7:0]  sfr_wdata,    // Register write data
  output logic      [7:0]  sfr_rdata,    // Registered read data
  input  wire logic        mux_en,       // Multiplexed address/data operation
  input  wire logic        xmove_req,    // External data-move request
  input  wire logic        xmove_write,  // Move direction, high for write
  input  wire logic [15:0] xmove_addr,   // Effective address
  input  wire logic [7:0]  xmove_wdata,  // Write data
  output logic             xmove_ready,  // Sequencer can take a request
  output logic             xmove_done,   // Access finished pulse
  output logic             xmove_offchip,// Finished access went off-chip
  output logic      [7:0]  xmove_rdata,  // Read data of last access
  output logic      [7:0]  addr_hi,      // Address pins 15:8
  output logic      [7:0]  addr_lo,      // Address pins 7:0, non-multiplexed
  input  wire logic [7:0]  ad_in,        // Data pins, input side
  output logic      [7:0]  ad_out,       // Data pins, output side
  output logic             ad_oe_n,      // Data pins enable, low drives
  output logic             ale,          // Address latch strobe
  output logic             rd_n,         // Read strobe, active low
  output logic             wr_n          // Write strobe, active low
);

  emc_state_t q;  // Registered state
  emc_state_t d;  // Next state

  // Decide whether an address goes off-chip in a given mode
  function automatic logic is_offchip(input logic [1:0] m, input logic [15:0] a);
    logic r;
    r = 1'b0;
    if (m == EMC_MODE_EXTERNAL) begin
      r = 1'b1;
    end else if (m == EMC_MODE_SPLIT || m == EMC_MODE_SPLIT_BS) begin
      r = (a >= XRAM_SIZE);
    end
    return r;
  endfunction

  // Leave the latch or start phase: setup if any, else strobe
  function automatic emc_state_t after_addr(input emc_state_t s);
    emc_state_t r;
    r = s;
    if (s.setup_cyc != 2'h0) begin
      r.st  = EMC_SETUP;
      r.cnt = {2'h0, s.setup_cyc - 2'h1};
    end else begin
      r.st   = EMC_STROBE;
      r.cnt  = s.strobe_cyc;
      r.rd_n = s.wr;
      r.wr_n = ~s.wr;
    end
    r.ad_out  = s.wdata;
    r.ad_oe_n = ~s.wr;
    return r;
  endfunction

  // Begin the strobe phase after setup
  function automatic emc_state_t to_strobe(input emc_state_t s);
    emc_state_t r;
    r      = s;
    r.st   = EMC_STROBE;
    r.cnt  = s.strobe_cyc;
    r.rd_n = s.wr;
    r.wr_n = ~s.wr;
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.s1   = ad_in;
    d.s2   = q.s1;
    d.s3   = q.s2;
    // Register read, unmapped reads zero
    if (sfr_page == `EMC_SFR_PAGE && sfr_addr == `EMC_CFG_ADDR) begin
      d.sfr_rdata = {4'h0, q.mode, q.alew};
    end else if (sfr_page == `EMC_SFR_PAGE && sfr_addr == `EMC_TC_ADDR) begin
      d.sfr_rdata = q.tc;
    end else begin
      d.sfr_rdata = 8'h00;
    end
    // Register write, upper bits dropped
    if (sfr_wr && sfr_page == `EMC_SFR_PAGE && sfr_addr == `EMC_CFG_ADDR) begin
      d.mode = sfr_wdata[`EMC_CFG_MODE_HI:`EMC_CFG_MODE_LO];
      d.alew = sfr_wdata[`EMC_CFG_ALE_HI:`EMC_CFG_ALE_LO];
    end else if (sfr_wr && sfr_page == `EMC_SFR_PAGE && sfr_addr == `EMC_TC_ADDR) begin
      d.tc = sfr_wdata;
    end
    // Filter holds the strobe's last cycle and the next: take read data
    if (!q.wr && q.s2 == q.s3 && ((q.st == EMC_TAIL && q.cnt == {2'h0, q.hold_cyc})
        || (q.st == EMC_HOLD && q.cnt == 4'h0 && q.hold_cyc == 2'h3))) begin
      d.rdata = q.s3;
    end
    // Access sequencer
    case (q.st)
      EMC_IDLE: begin
        if (xmove_req) begin
          d.wr    = xmove_write;
          d.addr  = xmove_addr;
          d.wdata = xmove_wdata;
          d.offchip = is_offchip(q.mode, xmove_addr);
          if (is_offchip(q.mode, xmove_addr)) begin
            // Timing snapshot for the whole access
            d.st  = EMC_START;
            d.setup_cyc  = q.tc[`EMC_TC_SETUP_HI:`EMC_TC_SETUP_LO];
            d.strobe_cyc = q.tc[`EMC_TC_STROBE_HI:`EMC_TC_STROBE_LO];
            d.hold_cyc   = q.tc[`EMC_TC_HOLD_HI:`EMC_TC_HOLD_LO];
            d.aw  = q.alew;
            d.mux = mux_en;
          end else begin
            d.done = 1'b1;  // On-chip move completes at once
          end
        end
      end
      EMC_START: begin
        if (q.mux) begin
          d.st      = EMC_ALE_HI;
          d.cnt     = {2'h0, q.aw};
          d.ale     = 1'b1;
          d.ad_out  = q.addr[7:0];
          d.ad_oe_n = 1'b0;
        end else begin
          d = after_addr(d);
        end
      end
      EMC_ALE_HI: begin
        if (q.cnt == 4'h0) begin
          d.st  = EMC_ALE_LO;
          d.cnt = {2'h0, q.aw};
          d.ale = 1'b0;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      EMC_ALE_LO: begin
        if (q.cnt == 4'h0) begin
          d = after_addr(d);
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      EMC_SETUP: begin
        if (q.cnt == 4'h0) begin
          d = to_strobe(d);
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      EMC_STROBE: begin
        if (q.cnt == 4'h0) begin
          d.rd_n = 1'b1;
          d.wr_n = 1'b1;
          if (q.hold_cyc != 2'h0) begin
            d.st  = EMC_HOLD;
            d.cnt = {2'h0, q.hold_cyc - 2'h1};
          end else begin
            d.st  = EMC_TAIL;
            d.cnt = `EMC_TAIL_LOAD;
          end
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      EMC_HOLD: begin
        if (q.cnt == 4'h0) begin
          d.st  = EMC_TAIL;
          d.cnt = `EMC_TAIL_LOAD;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      EMC_TAIL: begin
        if (q.cnt == 4'h0) begin
          d.st      = EMC_IDLE;
          d.done    = 1'b1;
          d.ad_oe_n = 1'b1;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      default: begin
        d.st = EMC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.mode    <= 2'(`EMC_CFG_RESET >> `EMC_CFG_MODE_LO);
      q.alew    <= 2'(`EMC_CFG_RESET);
      q.tc      <= `EMC_TC_RESET;
      q.rd_n    <= 1'b1;
      q.wr_n    <= 1'b1;
      q.ad_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Output drive
  assign sfr_rdata     = q.sfr_rdata;
  assign xmove_ready   = (q.st == EMC_IDLE);
  assign xmove_done    = q.done;
  assign xmove_offchip = q.offchip;
  assign xmove_rdata   = q.rdata;
  assign addr_hi       = q.addr[15:8];
  assign addr_lo       = q.addr[7:0];
  assign ad_out        = q.ad_out;
  assign ad_oe_n       = q.ad_oe_n;
  assign ale           = q.ale;
  assign rd_n          = q.rd_n;
  assign wr_n          = q.wr_n;

  // Helper counters for checks
  logic [5:0] busy_cnt;   // Cycles of current off-chip access
  logic [3:0] ale_cnt;    // Cycles of latch strobe high
  logic [4:0] strb_cnt;   // Cycles of read or write strobe
  logic [1:0] setup_cnt;  // Cycles spent in setup
  logic [5:0] exp_len;    // Expected access length
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_cnt  <= 6'h00;
      ale_cnt   <= 4'h0;
      strb_cnt  <= 5'h00;
      setup_cnt <= 2'h0;
    end else begin
      busy_cnt  <= (q.st != EMC_IDLE) ? busy_cnt + 6'h01 : 6'h00;
      ale_cnt   <= q.ale ? ale_cnt + 4'h1 : 4'h0;
      strb_cnt  <= (!q.rd_n || !q.wr_n) ? strb_cnt + 5'h01 : 5'h00;
      setup_cnt <= (q.st == EMC_SETUP) ? setup_cnt + 2'h1 : 2'h0;
    end
  end
  assign exp_len = `EMC_FIXED_CYCLES + {4'h0, q.setup_cyc} + {2'h0, q.strobe_cyc}
                 + 6'h01 + {4'h0, q.hold_cyc} + (q.mux ? {3'h0, q.aw, 1'b0} + 6'h02 : 6'h00);

  // Request taken into the off-chip sequence
  sequence seq_offchip_take;
    xmove_ready && xmove_req && is_offchip(q.mode, xmove_addr);
  endsequence
  sequence seq_begin;
    q.st == EMC_START;
  endsequence

  chk_cfg_upper_zero: assert property (@(posedge clock) disable iff (rst)
    (sfr_page == `EMC_SFR_PAGE && sfr_addr == `EMC_CFG_ADDR) |=> sfr_rdata[7:4] == 4'h0)
    else $error("config upper bits not zero");
  chk_cfg_write: assert property (@(posedge clock) disable iff (rst)
    (sfr_wr && sfr_page == `EMC_SFR_PAGE && sfr_addr == `EMC_CFG_ADDR)
    |=> q.mode == $past(sfr_wdata[3:2]) && q.alew == $past(sfr_wdata[1:0]))
    else $error("config write not stored");
  chk_internal_mode: assert property (@(posedge clock) disable iff (rst)
    (xmove_ready && xmove_req && q.mode == EMC_MODE_INTERNAL) |=> xmove_done && !xmove_offchip)
    else $error("internal mode went off-chip");
  chk_ext_only: assert property (@(posedge clock) disable iff (rst)
    (xmove_ready && xmove_req && q.mode == EMC_MODE_EXTERNAL) |=> seq_begin)
    else $error("external-only move stayed on-chip");
  chk_take_start: assert property (@(posedge clock) disable iff (rst)
    seq_offchip_take |=> seq_begin ##1 !xmove_ready)
    else $error("off-chip access did not start");
  chk_ale_width: assert property (@(posedge clock) disable iff (rst)
    $fell(q.ale) |-> ale_cnt == {2'h0, q.aw} + 4'h1)
    else $error("latch strobe width wrong");
  chk_strobe_width: assert property (@(posedge clock) disable iff (rst)
    ($rose(q.rd_n && q.wr_n) && q.st != EMC_IDLE) |-> strb_cnt == {1'b0, q.strobe_cyc} + 5'h01)
    else $error("strobe width wrong");
  chk_setup_time: assert property (@(posedge clock) disable iff (rst)
    (q.st == EMC_STROBE && $past(q.st) != EMC_STROBE) |-> setup_cnt == q.setup_cyc)
    else $error("setup time wrong");
  chk_access_len: assert property (@(posedge clock) disable iff (rst)
    (q.st == EMC_TAIL && q.cnt == 4'h0) |-> busy_cnt + 6'h01 == exp_len ##1 xmove_done)
    else $error("access length wrong");
  chk_timing_frozen: assert property (@(posedge clock) disable iff (rst)
    (q.st != EMC_IDLE && q.st != EMC_START && $past(q.st) != EMC_IDLE)
    |-> $stable(q.setup_cyc) && $stable(q.strobe_cyc) && $stable(q.hold_cyc) && $stable(q.aw))
    else $error("timing changed mid-access");

endmodule // emc_ext_mem_if

// file: tb/emc_mem_model.sv
// Off-chip byte-wide memory answering the external strobes
`timescale 1ns/1ps
module emc_mem_model (
  input  wire logic       clock,
  input  wire logic       mux,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] addr_lo,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe_n,
  output logic      [7:0] ad_in
);
  logic [7:0] mem [256];       // Storage by low address byte
  logic [7:0] lat_q  = 8'h00;  // Address caught while latch strobe high
  logic [7:0] last_q = 8'h00;  // Last byte put on the data pins
  logic [1:0] hold_q = 2'h0;   // Data hold cycles left after read strobe
  logic [7:0] idx;             // Address in use
  assign idx = mux ? lat_q : addr_lo;
  // Latch, store on write strobe, keep read data a short hold time
  always @(posedge clock) begin
    if (ale) lat_q <= ad_out;
    if (!wr_n) mem[idx] <= ad_out;
    if (!rd_n) begin
      last_q <= mem[idx];
      hold_q <= 2'h3;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end
  end
  // Wire level: device drive wins, then memory, then the held byte, else a changed value
  assign ad_in = !ad_oe_n ? ad_out : !rd_n ? mem[idx] : (hold_q != 2'h0) ? last_q : ~last_q;
endmodule // emc_mem_model

// file: tb/emc_ext_mem_if_tb.sv
// Self-checking bench for the external memory interface
`timescale 1ns/1ps
`include "emc_defs.svh"
module emc_ext_mem_if_tb;
  import emc_pkg::*;
  // One access case with its settings
  typedef struct packed {
    logic [1:0]  mode;
    logic [1:0]  alew;
    logic [7:0]  tc;
    logic        mux;
    logic        wr;
    logic [15:0] a;
    logic [7:0]  d;
    logic        off;
  } emc_row_t;
  logic        clock     = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  sfr_page  = 8'h00;
  logic [7:0]  sfr_addr  = 8'h00;
  logic        sfr_wr    = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic        mux_en    = 1'b0;
  logic        req       = 1'b0;
  logic        wr        = 1'b0;
  logic [15:0] addr      = 16'h0000;
  logic [7:0]  wdata     = 8'h00;
  logic [7:0]  sfr_rdata, rdata, addr_hi, addr_lo, ad_in, ad_out;
  logic        ready, done, offchip, ad_oe_n, ale, rd_n, wr_n;
  int          n_fail    = 0;  // Mismatches
  int          compares  = 0;  // Comparisons
  // Ordinary cases: mode, width, timing, mux, write, address, data, off-chip
  emc_row_t rows [9] = '{
    {2'h3, 2'h0, 8'h00, 1'b0, 1'b1, 16'h0010, 8'ha5, 1'b1},
    {2'h3, 2'h0, 8'h00, 1'b0, 1'b0, 16'h0010, 8'ha5, 1'b1},
    {2'h3, 2'h3, 8'hff, 1'b1, 1'b1, 16'h0020, 8'h5a, 1'b1},
    {2'h3, 2'h1, 8'h44, 1'b1, 1'b0, 16'h0020, 8'h5a, 1'b1},
    {2'h0, 2'h3, 8'h00, 1'b0, 1'b0, 16'h2000, 8'h00, 1'b0},
    {2'h1, 2'h3, 8'h00, 1'b0, 1'b1, 16'h0fff, 8'h00, 1'b0},
    {2'h1, 2'h0, 8'h81, 1'b0, 1'b1, 16'h1000, 8'h3c, 1'b1},
    {2'h2, 2'h0, 8'h00, 1'b1, 1'b0, 16'h1000, 8'h3c, 1'b1},
    {2'h3, 2'h3, 8'hff, 1'b1, 1'b0, 16'h0020, 8'h5a, 1'b1}};
  emc_row_t quick = {2'h3, 2'h0, 8'h00, 1'b0, 1'b1, 16'h0030, 8'h77, 1'b1};
  emc_row_t slow  = {2'h3, 2'h0, 8'hfc, 1'b0, 1'b0, 16'h0030, 8'h77, 1'b1};

  emc_ext_mem_if u_dut (.clock(clock), .rst(rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mux_en(mux_en),
    .xmove_req(req), .xmove_write(wr), .xmove_addr(addr), .xmove_wdata(wdata),
    .xmove_ready(ready), .xmove_done(done), .xmove_offchip(offchip), .xmove_rdata(rdata),
    .addr_hi(addr_hi), .addr_lo(addr_lo), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
  emc_mem_model u_mem (.clock(clock), .mux(mux_en), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .addr_lo(addr_lo), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ad_in(ad_in));

  // Clock at 100 MHz
  always #5 clock = ~clock;

  // Compare and count
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic final_report;
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One register write cycle
  task automatic reg_wr(logic [7:0] pg, logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    sfr_page  <= pg;
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clock);
    sfr_wr    <= 1'b0;
    sfr_page  <= 8'h00;
  endtask
  // Register read and compare
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    @(posedge clock);
    @(negedge clock);
    chk(sfr_rdata, exp);
  endtask
  // Busy cycles an access should take
  function automatic int exp_n(emc_row_t r);
    return r.off ? 4 + r.tc[7:6] + r.tc[5:2] + 1 + r.tc[1:0] + (r.mux ? 2 * (r.alew + 1) : 0) : 0;
  endfunction
  // Program both registers
  task automatic cfg(emc_row_t r);
    reg_wr(8'h00, `EMC_CFG_ADDR, {4'h0, r.mode, r.alew});
    reg_wr(8'h00, `EMC_TC_ADDR, r.tc);
  endtask
  // One access, counting busy, latch and strobe cycles
  task automatic run(emc_row_t r);
    int n;
    int na;
    int ns;
    n  = 0;
    na = 0;
    ns = 0;
    @(posedge clock);
    req    <= 1'b1;
    wr     <= r.wr;
    addr   <= r.a;
    wdata  <= r.d;
    mux_en <= r.mux;
    @(posedge clock);
    req <= 1'b0;
    @(negedge clock);
    while (!ready && n < 200) begin
      n++;
      na += ale;
      ns += !(rd_n && wr_n);
      @(negedge clock);
    end
    chk(n, exp_n(r));
    chk(na, (r.off && r.mux) ? r.alew + 1 : 0);
    chk(ns, r.off ? r.tc[5:2] + 1 : 0);
    chk(done, 1'b1);
    chk(offchip, r.off);
    chk(addr_hi, r.a[15:8]);
    chk(addr_lo, r.a[7:0]);
    if (r.off && !r.wr) chk(rdata, r.d);
  endtask

  // Watchdog
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rd_chk(`EMC_CFG_ADDR, 8'h03);
    rd_chk(`EMC_TC_ADDR, 8'hff);
    foreach (rows[i]) begin
      cfg(rows[i]);
      run(rows[i]);
    end
    // Upper bits, other page and unmapped address
    reg_wr(8'h00, `EMC_CFG_ADDR, 8'hf6);
    rd_chk(`EMC_CFG_ADDR, 8'h06);
    reg_wr(8'h01, `EMC_CFG_ADDR, 8'h0d);
    rd_chk(`EMC_CFG_ADDR, 8'h06);
    reg_wr(8'h00, 8'hae, 8'h12);
    rd_chk(8'hae, 8'h00);
    // Timing written mid-access applies to the next one only
    cfg(quick);
    fork
      run(quick);
      begin
        repeat (3) @(posedge clock);
        reg_wr(8'h00, `EMC_TC_ADDR, 8'hfc);
      end
    join
    run(slow);
    // Second reset in mid-run
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    rd_chk(`EMC_CFG_ADDR, 8'h03);
    rd_chk(`EMC_TC_ADDR, 8'hff);
    final_report;
  end
endmodule // emc_ext_mem_if_tb
